// ==== sdf_regs.vh ====
`ifndef SDF_REGS_VH
`define SDF_REGS_VH

// frame layout
`define SDF_FRAME_BITS 40
`define SDF_FRAME_MSB 39
`define SDF_RW_BIT 39
`define SDF_ADDR_MSB 38
`define SDF_ADDR_LSB 32
`define SDF_DATA_MSB 31
`define SDF_DATA_W 32
`define SDF_ADDR_W 7
`define SDF_STAT_W 8
`define SDF_STAT_MSB 7

// bit counter
`define SDF_CNT_W 6
`define SDF_CNT_FULL 6'h28
`define SDF_CNT_ZERO 6'h00
`define SDF_CNT_ONE 6'h01

// reset values
`define SDF_STAT_RST 8'h00
`define SDF_DATA_RST 32'h00000000
`define SDF_ADDR_RST 7'h00
`define SDF_FRAME_RST 40'h0000000000
`define SDF_SYNC_IDLE 3'h5
`define SDF_PIN_IDLE 1'b1
`define SDF_OE_OFF 1'b1

`endif

// ==== sdf_sync.v ====
`timescale 1ns/1ns

module sdf_sync
#(
    parameter W = 3,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
)
(
    input wire mclk, // system clock
    input wire rst, // synchronous reset, active high
    input wire [W-1:0] async_in, // pin levels from outside the clock domain
    output wire [W-1:0] sync_out // levels after two flip-flops
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg meta_ff;
            reg stab_ff;
            always @(posedge mclk)
            begin
                if (rst)
                begin
                    meta_ff <= RST_VAL[i];
                    stab_ff <= RST_VAL[i];
                end
                else
                begin
                    meta_ff <= async_in[i];
                    stab_ff <= meta_ff;
                end
            end
            assign sync_out[i] = stab_ff;
        end
    endgenerate

endmodule

// ==== sdf_spi_slave.v ====
// What this block does
// - every exchange is a 40-bit frame, moved in whole bytes.
// - inbound frame is address byte in bits 39..32, data word 31..0.
// - every access exchanges a full 32-bit data word.
// - address top bit zero means read of the seven-bit address.
// - address top bit one means write of the data word.
// - registers are write-only, read-write or read-only.
// - MSB first; sample on rising clock, change output after falling clock.
// - last 40 bits count at select rise; extra bits pass after 40-bit delay.
// - data returned is prior read's register, or prior write's data.
// - status byte leads every outbound frame, latched at prior access end.
`timescale 1ns/1ns
`include "sdf_regs.vh"

module sdf_spi_slave
(
    input wire mclk, // 100 MHz system clock
    input wire rst, // synchronous reset, active high
    input wire sck, // serial clock pin from master
    input wire sdi, // serial data pin from master
    input wire frame_select_low, // frame select pin, active low
    output reg sdo_ff, // serial data out pin
    output reg sdo_oe_n_ff, // sdo output enable, low while driving
    input wire [7:0] status_in, // live status flags of the device
    input wire [31:0] rd_data, // register file read data for acc_addr_ff
    output reg [6:0] acc_addr_ff, // register address of last access
    output reg [31:0] wr_data_ff, // data word of last write
    output reg wr_strobe_ff, // one-cycle pulse: store wr_data_ff
    output reg rd_strobe_ff // one-cycle pulse: read acc_addr_ff
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [2:0] pin_s;
    wire sck_s;
    wire sdi_s;
    wire sel_n_s;

    // reset to pin idle levels: no false edge after reset
    sdf_sync #(.W(3), .RST_VAL(`SDF_SYNC_IDLE)) u_sync
    (
        .mclk(mclk),
        .rst(rst),
        .async_in({frame_select_low, sdi, sck}),
        .sync_out(pin_s)
    );

    assign sck_s = pin_s[0];
    assign sdi_s = pin_s[1];
    assign sel_n_s = pin_s[2];

    // ************************************************************
    // edge detection
    // ************************************************************
    reg sck_prev_ff;
    reg sel_prev_ff;
    wire sck_rise;
    wire sck_fall;
    wire sel_fall;
    wire sel_rise;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            sck_prev_ff <= `SDF_PIN_IDLE;
        end
        else
        begin
            sck_prev_ff <= sck_s;
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            sel_prev_ff <= `SDF_PIN_IDLE;
        end
        else
        begin
            sel_prev_ff <= sel_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_ff & ~sel_n_s;
    assign sck_fall = ~sck_s & sck_prev_ff & ~sel_n_s;
    assign sel_fall = ~sel_n_s & sel_prev_ff;
    assign sel_rise = sel_n_s & ~sel_prev_ff;

    // ************************************************************
    // shift register and bit count
    // ************************************************************
    reg [39:0] shift_ff;
    reg [5:0] cnt_ff;
    reg [7:0] status_ff;
    reg [31:0] ret_ff;
    reg rd_pend_ff;
    wire frame_ok;
    wire is_write;

    // frames short of the full count leave no trace
    assign frame_ok = (cnt_ff == `SDF_CNT_FULL);
    assign is_write = shift_ff[`SDF_RW_BIT];

    always @(posedge mclk)
    begin
        if (rst)
        begin
            shift_ff <= `SDF_FRAME_RST;
            cnt_ff <= `SDF_CNT_ZERO;
        end
        else if (sel_fall)
        begin
            shift_ff <= {status_ff, ret_ff};
            cnt_ff <= `SDF_CNT_ZERO;
        end
        else if (sck_rise)
        begin
            // msb first in and out; one register gives the 40-bit delay
            shift_ff <= {shift_ff[`SDF_FRAME_MSB-1:0], sdi_s};
            if (cnt_ff != `SDF_CNT_FULL)
            begin
                cnt_ff <= cnt_ff + `SDF_CNT_ONE;
            end
        end
    end

    // ************************************************************
    // serial output
    // ************************************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            sdo_oe_n_ff <= `SDF_OE_OFF;
        end
        else if (sel_fall)
        begin
            sdo_oe_n_ff <= ~`SDF_OE_OFF;
        end
        else if (sel_rise)
        begin
            sdo_oe_n_ff <= `SDF_OE_OFF;
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            sdo_ff <= 1'b0;
        end
        else if (sel_fall)
        begin
            sdo_ff <= status_ff[`SDF_STAT_MSB];
        end
        else if (sck_fall)
        begin
            sdo_ff <= shift_ff[`SDF_FRAME_MSB];
        end
    end

    // ************************************************************
    // command decode at end of frame
    // ************************************************************
    wire frame_done;

    // only the last 40 bits before select rise count
    assign frame_done = sel_rise & frame_ok;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            wr_strobe_ff <= 1'b0;
            rd_strobe_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end
        else
        begin
            wr_strobe_ff <= frame_done & is_write;
            rd_strobe_ff <= frame_done & ~is_write;
            // register file gets one cycle to answer a read
            rd_pend_ff <= rd_strobe_ff;
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            acc_addr_ff <= `SDF_ADDR_RST;
            wr_data_ff <= `SDF_DATA_RST;
            status_ff <= `SDF_STAT_RST;
        end
        else if (frame_done)
        begin
            acc_addr_ff <= shift_ff[`SDF_ADDR_MSB:`SDF_ADDR_LSB];
            status_ff <= status_in;
            if (is_write)
            begin
                wr_data_ff <= shift_ff[`SDF_DATA_MSB:0];
            end
        end
    end

    // ************************************************************
    // return word for the next frame
    // ************************************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            ret_ff <= `SDF_DATA_RST;
        end
        else if (frame_done & is_write)
        begin
            // a write echoes its own data word
            ret_ff <= shift_ff[`SDF_DATA_MSB:0];
        end
        else if (rd_pend_ff)
        begin
            // register file answers for any address kind
            ret_ff <= rd_data;
        end
    end

endmodule

// ==== sdf_properties.sv ====
`timescale 1ns/1ns
module sdf_props(
    input wire mclk, // clock
    input wire rst, // reset
    input wire sck, // clock pin
    input wire sdi, // data in
    input wire frame_select_low, // select
    input wire sdo_ff, // data out
    input wire sdo_oe_n_ff, // out enable
    input wire [7:0] status_in, // status
    input wire [31:0] rd_data, // read word
    input wire [6:0] acc_addr_ff, // address
    input wire [31:0] wr_data_ff, // write word
    input wire wr_strobe_ff, // write pulse
    input wire rd_strobe_ff // read pulse
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_oe_idle: assert property (frame_select_low [*5] |-> sdo_oe_n_ff)
        else $error("sdo driven while idle");
    a_one_strobe: assert property (!(wr_strobe_ff && rd_strobe_ff))
        else $error("both strobes");
    a_wr_pulse: assert property (wr_strobe_ff |=> !wr_strobe_ff)
        else $error("long write pulse");
    a_rd_pulse: assert property (rd_strobe_ff |=> !rd_strobe_ff)
        else $error("long read pulse");
    a_strobe_idle: assert property ((wr_strobe_ff || rd_strobe_ff) |-> frame_select_low && $past(frame_select_low))
        else $error("strobe inside frame");
    a_addr_hold: assert property (!$stable(acc_addr_ff) |-> wr_strobe_ff || rd_strobe_ff)
        else $error("address moved alone");
    a_wdata_hold: assert property (!$stable(wr_data_ff) |-> wr_strobe_ff)
        else $error("write word moved alone");
    a_oe_start: assert property ($fell(sdo_oe_n_ff) |-> !frame_select_low)
        else $error("enable without select");
    a_oe_end: assert property ($rose(sdo_oe_n_ff) |-> frame_select_low)
        else $error("enable dropped in frame");
    a_oe_frame: assert property (!frame_select_low [*5] |-> !sdo_oe_n_ff)
        else $error("sdo not driven in frame");
endmodule
bind sdf_spi_slave sdf_props u_props
(
    .mclk(mclk),
    .rst(rst),
    .sck(sck),
    .sdi(sdi),
    .frame_select_low(frame_select_low),
    .sdo_ff(sdo_ff),
    .sdo_oe_n_ff(sdo_oe_n_ff),
    .status_in(status_in),
    .rd_data(rd_data),
    .acc_addr_ff(acc_addr_ff),
    .wr_data_ff(wr_data_ff),
    .wr_strobe_ff(wr_strobe_ff),
    .rd_strobe_ff(rd_strobe_ff)
);

// ==== sdf_master.sv ====
`timescale 1ns/1ns
module sdf_master(
    output logic sck, // clock pin
    output logic sdi, // data to device
    output logic frame_select_low, // select
    input wire sdo // data from device
);
    initial
    begin
        sck = 1'b1;
        sdi = 1'b0;
        frame_select_low = 1'b1;
    end
    // n is a multiple of eight
    task automatic xfer(input int n, input [47:0] tx, output [47:0] rx);
        rx = '0;
        frame_select_low = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--)
        begin
            sck = 1'b0;
            sdi = tx[i];
            #60;
            sck = 1'b1;
            rx[i] = sdo;
            #60;
        end
        frame_select_low = 1'b1;
        sdi = ~sdi;
        #200;
    endtask
endmodule

// ==== spi_datagram_framing_test.sv ====
`timescale 1ns/1ns
module spi_datagram_framing_test;
    logic mclk;
    logic rst;
    logic [7:0] status_in;
    wire sck, sdi, frame_select_low, sdo_ff, oe_n, wr_s, rd_s;
    wire [6:0] addr;
    wire [31:0] wdata;
    wire [31:0] rd_data = {4{1'b0, addr}};
    wire sdo = sdo_ff ^ oe_n;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int nw = 0;
    int nr = 0;
    logic [47:0] rx;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t mismatch got %h want %h", $time, (a), (b)); end end
    sdf_master m(.sck(sck), .sdi(sdi), .frame_select_low(frame_select_low), .sdo(sdo));
    sdf_spi_slave uut(.mclk(mclk), .rst(rst), .sck(sck), .sdi(sdi), .frame_select_low(frame_select_low),
        .sdo_ff(sdo_ff), .sdo_oe_n_ff(oe_n), .status_in(status_in), .rd_data(rd_data), .acc_addr_ff(addr),
        .wr_data_ff(wdata), .wr_strobe_ff(wr_s), .rd_strobe_ff(rd_s));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk)
    begin
        nw += wr_s;
        nr += rd_s;
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            summarize;
        end
    end
    task summarize;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_write;
        status_in = 8'h5A;
        m.xfer(40, 48'h85DEADBEEF, rx);
        `CHK(rx[39:0], 40'h0)
        `CHK(addr, 7'h05)
        `CHK(wdata, 32'hDEADBEEF)
        `CHK(nw, 1)
        `CHK(nr, 0)
        $display("t_write done");
    endtask
    task t_read;
        status_in = 8'h3C;
        m.xfer(40, 48'h2100000000, rx);
        `CHK(rx[39:0], 40'h5ADEADBEEF)
        `CHK(nr, 1)
        `CHK(nw, 1)
        `CHK(addr, 7'h21)
        `CHK(wdata, 32'hDEADBEEF)
        m.xfer(40, 48'h9000000001, rx);
        `CHK(rx[39:0], 40'h3C21212121)
        $display("t_read done");
    endtask
    task t_short;
        m.xfer(32, 48'h8400000055, rx);
        `CHK(rx[31:0], 32'h3C000000)
        `CHK(addr, 7'h10)
        `CHK(nw, 2)
        $display("t_short done");
    endtask
    task t_long;
        m.xfer(48, 48'hC38212345678, rx);
        `CHK(rx[47:8], 40'h3C00000001)
        `CHK(rx[7:0], 8'hC3)
        `CHK(addr, 7'h02)
        `CHK(wdata, 32'h12345678)
        $display("t_long done");
    endtask
    task t_reset;
        @(negedge mclk);
        rst = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(addr, 7'h00)
        `CHK(wdata, 32'h0)
        `CHK(oe_n, 1'b1)
        `CHK(sdo_ff, 1'b0)
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        m.xfer(40, 48'h0300000000, rx);
        `CHK(rx[39:0], 40'h0)
        `CHK(nr, 2)
        m.xfer(40, 48'h0000000000, rx);
        `CHK(rx[39:0], 40'h3C03030303)
        $display("t_reset done");
    endtask
    initial
    begin
        rst = 1'b1;
        status_in = 8'h00;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_write;
        t_read;
        t_short;
        t_long;
        t_reset;
        summarize;
    end
endmodule
